// >>> ttc_pkg.sv
`default_nettype none
package ttc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_TCTL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_REQ = 8'h08;
  localparam logic [7:0] ADDR_TGT = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_ISTAT = 8'h14;
  localparam logic [7:0] ADDR_IMASK = 8'h18;
  // field positions
  localparam int TCTL_DUTY_LSB = 1;
  localparam int TCTL_FORCE_BIT = 4;
  localparam int MODE_MOD_BIT = 0;
  localparam int MODE_FREQ_BIT = 1;
  localparam int IRQ_HOT_ON = 0;
  localparam int IRQ_HOT_OFF = 1;
  localparam int IRQ_TRIP = 2;
  // reset values
  localparam logic [2:0] DUTY_RST = 3'h4;
  localparam logic [3:0] REQ_RST = 4'hF;
  localparam logic [3:0] TGT_RST = 4'h4;
  localparam logic [2:0] IMASK_RST = 3'h0;
  // fixed automatic on-time in eighths
  localparam logic [2:0] AUTO_ON_EIGHTHS = 3'h4;
  // core cycles per eighth of a modulation period
  localparam logic [7:0] STEP_CYC = 8'h10;
  typedef enum logic [1:0] {
    TTC_FS_IDLE = 2'b01,
    TTC_FS_STEP = 2'b10
  } ttc_fs_e;
  typedef struct packed {
    logic s1;
    logic s2;
  } ttc_sync_s;
  typedef struct packed {
    logic [2:0] step;
    logic [7:0] cnt;
    logic on;
  } ttc_mod_s;
  typedef struct packed {
    logic over_trip;
    logic under_release;
    logic over_critical;
    logic lp_state;
  } ttc_temp_s;
  typedef struct packed {
    ttc_fs_e fs;
    logic [2:0] duty;
    logic force_en;
    logic mod_en;
    logic freq_en;
    logic [3:0] sw_req;
    logic [3:0] tgt;
    logic [3:0] cur;
    logic hot;
    logic hot_alarm_n;
    logic trip;
    logic core_clk_en;
    logic throttle_active;
    logic [2:0] istat;
    logic [2:0] imask;
    logic irq;
    logic [31:0] rdata;
    logic snoop_ack;
    logic intr_latch;
  } ttc_state_s;
endpackage
`default_nettype wire

// >>> ttc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ttc_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  ttc_pkg::ttc_sync_s st_r;
  ttc_pkg::ttc_sync_s st_nxt;
  always_comb begin
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign dout = st_r.s2;
endmodule
`default_nettype wire

// >>> ttc_clk_mod.sv
`timescale 1ns/100ps
`default_nettype none
module ttc_clk_mod (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] on_eighths,
  output logic gate_on
);
  ttc_pkg::ttc_mod_s st_r;
  ttc_pkg::ttc_mod_s st_nxt;
  // period is a fixed count of core cycles, so it shrinks as clock rises
  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      st_nxt.step = 3'h0;
      st_nxt.cnt = 8'h00;
      st_nxt.on = 1'b1;
    end else begin
      if (st_r.cnt == ttc_pkg::STEP_CYC - 8'h01) begin
        st_nxt.cnt = 8'h00;
        st_nxt.step = st_r.step + 3'h1;
      end else begin
        st_nxt.cnt = st_r.cnt + 8'h01;
      end
      st_nxt.on = (st_nxt.step < on_eighths);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '{step: 3'h0, cnt: 8'h00, on: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign gate_on = st_r.on;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_mod_ratio;
    $past(run) && run && $stable(on_eighths)
      |-> st_r.on == (st_r.step < on_eighths);
  endproperty
  a_mod_ratio: assert property (p_mod_ratio)
    else $error("modulation on-time does not match selected eighths");
endmodule
`default_nettype wire

// >>> ttc_top.sv
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ttc_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire ttc_pkg::ttc_temp_s temp_pins,
  input wire logic snoop_req,
  input wire logic intr_req,
  input wire logic intr_ack,
  output logic core_clk_en,
  output logic [3:0] op_point,
  output logic throttle_active,
  output logic hot_alarm_n,
  output logic catastrophic_trip_n,
  output logic snoop_ack,
  output logic intr_latch,
  output logic irq
);
  ttc_pkg::ttc_state_s st_r;
  ttc_pkg::ttc_state_s st_nxt;
  ttc_pkg::ttc_temp_s ts;
  logic gate_on;
  logic auto_mod;
  logic forced;
  logic mod_run;
  logic [2:0] mod_eighths;
  logic req_wr;
  logic tgt_wr;
  logic [3:0] req_val;
  logic [2:0] w1c;
  logic [2:0] ev;

  ttc_sync u_sync_trip (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(temp_pins.over_trip),
    .dout(ts.over_trip)
  );
  ttc_sync u_sync_rel (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(temp_pins.under_release),
    .dout(ts.under_release)
  );
  ttc_sync u_sync_crit (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(temp_pins.over_critical),
    .dout(ts.over_critical)
  );
  ttc_sync u_sync_lp (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(temp_pins.lp_state),
    .dout(ts.lp_state)
  );

  // modulation source: automatic wins over forced
  always_comb begin
    auto_mod = st_r.hot && st_r.mod_en;
    forced = st_r.force_en && (st_r.duty != 3'h0);
    mod_run = !st_r.trip && (auto_mod || forced);
    if (auto_mod) begin
      mod_eighths = ttc_pkg::AUTO_ON_EIGHTHS;
    end else begin
      mod_eighths = st_r.duty;
    end
  end

  ttc_clk_mod u_mod (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(mod_run),
    .on_eighths(mod_eighths),
    .gate_on(gate_on)
  );

  assign req_wr = wr && (addr == ttc_pkg::ADDR_REQ);
  assign tgt_wr = wr && (addr == ttc_pkg::ADDR_TGT);
  assign req_val = wdata[3:0];

  always_comb begin
    st_nxt = st_r;
    w1c = 3'h0;
    // register writes
    if (wr) begin
      case (addr)
        ttc_pkg::ADDR_TCTL: begin
          st_nxt.duty = wdata[ttc_pkg::TCTL_DUTY_LSB +: 3];
          st_nxt.force_en = wdata[ttc_pkg::TCTL_FORCE_BIT];
        end
        ttc_pkg::ADDR_MODE: begin
          st_nxt.mod_en = wdata[ttc_pkg::MODE_MOD_BIT];
          st_nxt.freq_en = wdata[ttc_pkg::MODE_FREQ_BIT];
        end
        ttc_pkg::ADDR_REQ: begin
          st_nxt.sw_req = req_val;
        end
        ttc_pkg::ADDR_TGT: begin
          st_nxt.tgt = wdata[3:0];
        end
        ttc_pkg::ADDR_ISTAT: begin
          w1c = wdata[2:0];
        end
        ttc_pkg::ADDR_IMASK: begin
          st_nxt.imask = wdata[2:0];
        end
        default: begin
        end
      endcase
    end
    // over-temperature with separate release threshold
    if (ts.over_trip) begin
      st_nxt.hot = 1'b1;
    end else if (ts.under_release) begin
      st_nxt.hot = 1'b0;
    end
    // alarm frozen while clocks are stopped
    if (ts.lp_state) begin
      st_nxt.hot_alarm_n = st_r.hot_alarm_n;
    end else begin
      st_nxt.hot_alarm_n = !st_nxt.hot;
    end
    // catastrophic trip is sticky until reset
    if (ts.over_critical) begin
      st_nxt.trip = 1'b1;
    end
    // operating point state machine
    case (st_r.fs)
      ttc_pkg::TTC_FS_IDLE: begin
        st_nxt.cur = st_nxt.sw_req;
        if (st_r.hot && st_r.freq_en) begin
          st_nxt.fs = ttc_pkg::TTC_FS_STEP;
          if (st_nxt.sw_req < st_nxt.tgt) begin
            st_nxt.cur = st_nxt.sw_req;
          end else begin
            st_nxt.cur = st_nxt.tgt;
          end
        end
      end
      ttc_pkg::TTC_FS_STEP: begin
        if (!st_r.hot || !st_r.freq_en) begin
          st_nxt.fs = ttc_pkg::TTC_FS_IDLE;
          st_nxt.cur = st_nxt.sw_req;
        end else if (req_wr) begin
          if (req_val < st_r.tgt) begin
            st_nxt.cur = req_val;
          end else begin
            st_nxt.cur = st_r.cur;
          end
        end
      end
      default: begin
        st_nxt.fs = ttc_pkg::TTC_FS_IDLE;
        st_nxt.cur = st_nxt.sw_req;
      end
    endcase
    // clock gate: trip stops the core outright
    st_nxt.core_clk_en = !st_nxt.trip && gate_on;
    st_nxt.throttle_active = st_r.trip || mod_run
      || (st_r.fs == ttc_pkg::TTC_FS_STEP);
    // snoops and interrupt latching ignore throttle state
    st_nxt.snoop_ack = snoop_req;
    if (intr_req) begin
      st_nxt.intr_latch = 1'b1;
    end else if (intr_ack) begin
      st_nxt.intr_latch = 1'b0;
    end
    // sticky events, set wins over clear
    ev[ttc_pkg::IRQ_HOT_ON] = st_nxt.hot && !st_r.hot;
    ev[ttc_pkg::IRQ_HOT_OFF] = !st_nxt.hot && st_r.hot;
    ev[ttc_pkg::IRQ_TRIP] = st_nxt.trip && !st_r.trip;
    st_nxt.istat = (st_r.istat & ~w1c) | ev;
    st_nxt.irq = |(st_nxt.istat & st_nxt.imask);
    // read data valid the cycle after the strobe
    st_nxt.rdata = 32'h0000_0000;
    if (rd) begin
      case (addr)
        ttc_pkg::ADDR_TCTL: begin
          st_nxt.rdata[ttc_pkg::TCTL_DUTY_LSB +: 3] = st_r.duty;
          st_nxt.rdata[ttc_pkg::TCTL_FORCE_BIT] = st_r.force_en;
        end
        ttc_pkg::ADDR_MODE: begin
          st_nxt.rdata[ttc_pkg::MODE_MOD_BIT] = st_r.mod_en;
          st_nxt.rdata[ttc_pkg::MODE_FREQ_BIT] = st_r.freq_en;
        end
        ttc_pkg::ADDR_REQ: begin
          st_nxt.rdata[3:0] = st_r.sw_req;
        end
        ttc_pkg::ADDR_TGT: begin
          st_nxt.rdata[3:0] = st_r.tgt;
        end
        ttc_pkg::ADDR_STAT: begin
          st_nxt.rdata[8:0] = {st_r.cur, (st_r.fs == ttc_pkg::TTC_FS_STEP),
            st_r.throttle_active, st_r.hot, st_r.trip, st_r.core_clk_en};
        end
        ttc_pkg::ADDR_ISTAT: begin
          st_nxt.rdata[2:0] = st_r.istat;
        end
        ttc_pkg::ADDR_IMASK: begin
          st_nxt.rdata[2:0] = st_r.imask;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '{fs: ttc_pkg::TTC_FS_IDLE, duty: ttc_pkg::DUTY_RST,
        force_en: 1'b0, mod_en: 1'b0, freq_en: 1'b0,
        sw_req: ttc_pkg::REQ_RST, tgt: ttc_pkg::TGT_RST,
        cur: ttc_pkg::REQ_RST, hot: 1'b0, hot_alarm_n: 1'b1,
        trip: 1'b0, core_clk_en: 1'b1, throttle_active: 1'b0,
        istat: 3'h0, imask: ttc_pkg::IMASK_RST, irq: 1'b0,
        rdata: 32'h0000_0000, snoop_ack: 1'b0, intr_latch: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign core_clk_en = st_r.core_clk_en;
  assign op_point = st_r.cur;
  assign throttle_active = st_r.throttle_active;
  assign hot_alarm_n = st_r.hot_alarm_n;
  assign catastrophic_trip_n = !st_r.trip;
  assign snoop_ack = st_r.snoop_ack;
  assign intr_latch = st_r.intr_latch;
  assign irq = st_r.irq;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_step_hot;
    st_r.fs == ttc_pkg::TTC_FS_STEP && st_r.hot && st_r.freq_en;
  endsequence
  sequence s_force_write;
    wr && addr == ttc_pkg::ADDR_TCTL && wdata[ttc_pkg::TCTL_FORCE_BIT]
      && wdata[ttc_pkg::TCTL_DUTY_LSB +: 3] != 3'h0;
  endsequence

  property p_step_enter;
    st_r.fs == ttc_pkg::TTC_FS_IDLE && st_r.hot && st_r.freq_en
      && !req_wr && !tgt_wr
      |=> st_r.fs == ttc_pkg::TTC_FS_STEP && st_r.cur <= st_r.tgt;
  endproperty
  a_step_enter: assert property (p_step_enter)
    else $error("hot die did not lower the operating point");

  property p_step_exit;
    st_r.fs == ttc_pkg::TTC_FS_STEP && !st_r.hot
      |=> st_r.fs == ttc_pkg::TTC_FS_IDLE && st_r.cur == st_r.sw_req;
  endproperty
  a_step_exit: assert property (p_step_exit)
    else $error("cooling did not restore the requested point");

  property p_defer;
    s_step_hot ##0 (req_wr && req_val >= st_r.tgt)
      |=> st_r.cur == $past(st_r.cur) && st_r.sw_req == $past(req_val);
  endproperty
  a_defer: assert property (p_defer)
    else $error("high request was not deferred");

  property p_direct;
    s_step_hot ##0 (req_wr && req_val < st_r.tgt)
      |=> st_r.cur == $past(req_val);
  endproperty
  a_direct: assert property (p_direct)
    else $error("low request was not applied at once");

  property p_auto_ratio;
    st_r.hot && st_r.mod_en && !st_r.trip
      |-> mod_run && mod_eighths == ttc_pkg::AUTO_ON_EIGHTHS;
  endproperty
  a_auto_ratio: assert property (p_auto_ratio)
    else $error("automatic modulation not at fixed half ratio");

  property p_forced_duty;
    st_r.force_en && st_r.duty != 3'h0 && !(st_r.hot && st_r.mod_en)
      && !st_r.trip |-> mod_run && mod_eighths == st_r.duty;
  endproperty
  a_forced_duty: assert property (p_forced_duty)
    else $error("forced mode ignores duty field");

  property p_force_now;
    s_force_write |=> ##1 st_r.throttle_active;
  endproperty
  a_force_now: assert property (p_force_now)
    else $error("forced enable did not activate throttle");

  property p_release;
    st_r.fs == ttc_pkg::TTC_FS_IDLE && !st_r.hot && !st_r.force_en
      && !st_r.trip |=> !st_r.throttle_active;
  endproperty
  a_release: assert property (p_release)
    else $error("throttle stayed active after cooling");

  property p_hyst;
    st_r.hot && !ts.under_release |=> st_r.hot;
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("hot cleared above release threshold");

  property p_alarm;
    !ts.lp_state |=> st_r.hot_alarm_n == !st_r.hot;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("hot alarm does not follow die state");

  property p_lp_no_new;
    ts.lp_state && st_r.hot_alarm_n |=> st_r.hot_alarm_n;
  endproperty
  a_lp_no_new: assert property (p_lp_no_new)
    else $error("hot alarm newly asserted in low-power state");

  property p_lp_hold;
    ts.lp_state && !st_r.hot_alarm_n |=> !st_r.hot_alarm_n;
  endproperty
  a_lp_hold: assert property (p_lp_hold)
    else $error("hot alarm dropped inside low-power state");

  property p_trip;
    ts.over_critical |=> !catastrophic_trip_n && !core_clk_en;
  endproperty
  a_trip: assert property (p_trip)
    else $error("critical temperature did not trip and stop core");

  property p_trip_sticky;
    !catastrophic_trip_n |=> !catastrophic_trip_n [*2];
  endproperty
  a_trip_sticky: assert property (p_trip_sticky)
    else $error("catastrophic trip released without reset");

  property p_snoop;
    snoop_req |=> snoop_ack;
  endproperty
  a_snoop: assert property (p_snoop)
    else $error("snoop not answered while throttled");
endmodule
`default_nettype wire

// >>> ttc_platform.sv
`timescale 1ns/100ps
`default_nettype none
// platform side: die comparators and core supply switch
module ttc_platform #(
  parameter int CUT_CYC = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] level,
  input wire logic lp_state,
  input wire logic catastrophic_trip_n,
  output var ttc_pkg::ttc_temp_s temp_pins,
  output logic power_on
);
  // level 0 cool, 1 inside the hysteresis band, 2 hot, 3 critical
  int cut_cnt;
  always_comb begin
    temp_pins.over_trip = (level >= 2'h2);
    temp_pins.under_release = (level == 2'h0);
    temp_pins.over_critical = (level == 2'h3);
    temp_pins.lp_state = lp_state;
  end
  // supply removed a bounded time after the trip output goes low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cut_cnt <= 0;
      power_on <= 1'b1;
    end else if (!catastrophic_trip_n) begin
      if (cut_cnt == CUT_CYC) begin
        power_on <= 1'b0;
      end else begin
        cut_cnt <= cut_cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb_thermal_throttle_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_thermal_throttle_control;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic snoop_req = 1'b0;
  logic intr_req = 1'b0;
  logic intr_ack = 1'b0;
  logic [1:0] lvl = 2'h0;
  logic lp = 1'b0;
  ttc_pkg::ttc_temp_s temp_pins;
  logic [31:0] rdata;
  logic core_clk_en, throttle_active, hot_alarm_n, catastrophic_trip_n;
  logic snoop_ack, intr_latch, irq, power_on;
  logic [3:0] op_point;
  logic [31:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [31:0] cnt;
  logic [3:0] req;
  int num_errors = 0;
  int checks_done = 0;

  always #5 ref_clk = ~ref_clk;

  ttc_top dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .temp_pins(temp_pins),
    .snoop_req(snoop_req), .intr_req(intr_req), .intr_ack(intr_ack),
    .core_clk_en(core_clk_en), .op_point(op_point),
    .throttle_active(throttle_active), .hot_alarm_n(hot_alarm_n),
    .catastrophic_trip_n(catastrophic_trip_n), .snoop_ack(snoop_ack),
    .intr_latch(intr_latch), .irq(irq));

  ttc_platform u_plat (.ref_clk(ref_clk), .rst(rst), .level(lvl),
    .lp_state(lp), .catastrophic_trip_n(catastrophic_trip_n),
    .temp_pins(temp_pins), .power_on(power_on));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(exp);
    @(posedge ref_clk);
    rd <= 1'b0;
  endtask

  task wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task count_on(output logic [31:0] n);
    n = 32'h0;
    repeat (128) begin
      @(posedge ref_clk);
      if (core_clk_en === 1'b1) n++;
    end
  endtask

  // read data stand only in the cycle after the read strobe
  always @(posedge ref_clk) begin
    if (rd_seen) check(rdata, exp_q.pop_front());
    rd_seen <= rd;
  end

  initial begin
    wait_cyc(20000);
    num_errors++;
    results();
  end

  initial begin
    void'($urandom(32'hb9cf));
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    wait_cyc(3);
    check(core_clk_en, 1'b1);
    check(op_point, 4'hF);
    check(hot_alarm_n, 1'b1);
    check(catastrophic_trip_n, 1'b1);
    check(irq, 1'b0);
    rd_reg(ttc_pkg::ADDR_REQ, 32'(ttc_pkg::REQ_RST));
    rd_reg(ttc_pkg::ADDR_TGT, 32'(ttc_pkg::TGT_RST));
    rd_reg(ttc_pkg::ADDR_IMASK, 32'(ttc_pkg::IMASK_RST));
    rd_reg(ttc_pkg::ADDR_TCTL, 32'(ttc_pkg::DUTY_RST) << 1);
    rd_reg(8'h20, 32'h0);
    // forced duty sweep, zero is reserved and leaves the clock on
    for (int n = 0; n < 8; n++) begin
      wr_reg(ttc_pkg::ADDR_TCTL, 32'h10 | (n << 1));
      wait_cyc(300);
      count_on(cnt);
      check(cnt, (n == 0) ? 32'd128 : n * 16);
      if (n != 0) check(throttle_active, 1'b1);
    end
    wr_reg(ttc_pkg::ADDR_TCTL, 32'h12);
    wr_reg(ttc_pkg::ADDR_IMASK, 32'h1);
    wr_reg(ttc_pkg::ADDR_MODE, 32'h1);
    lvl <= 2'h2;
    wait_cyc(6);
    check(hot_alarm_n, 1'b0);
    check(irq, 1'b1);
    wait_cyc(300);
    count_on(cnt);
    check(cnt, 32'd64);
    rd_reg(ttc_pkg::ADDR_ISTAT, 32'h1);
    wr_reg(ttc_pkg::ADDR_ISTAT, 32'h1);
    wait_cyc(2);
    check(irq, 1'b0);
    @(posedge ref_clk);
    snoop_req <= 1'b1;
    intr_req <= 1'b1;
    @(posedge ref_clk);
    snoop_req <= 1'b0;
    intr_req <= 1'b0;
    #1;
    check(snoop_ack, 1'b1);
    check(intr_latch, 1'b1);
    @(posedge ref_clk);
    intr_ack <= 1'b1;
    @(posedge ref_clk);
    intr_ack <= 1'b0;
    wait_cyc(1);
    check(intr_latch, 1'b0);
    lvl <= 2'h1;
    wait_cyc(8);
    check(hot_alarm_n, 1'b0);
    check(throttle_active, 1'b1);
    wr_reg(ttc_pkg::ADDR_TCTL, 32'h0);
    lvl <= 2'h0;
    wait_cyc(8);
    check(hot_alarm_n, 1'b1);
    check(throttle_active, 1'b0);
    check(core_clk_en, 1'b1);
    rd_reg(ttc_pkg::ADDR_ISTAT, 32'h2);
    // frequency step with deferred and direct requests
    wr_reg(ttc_pkg::ADDR_MODE, 32'h2);
    lvl <= 2'h2;
    wait_cyc(8);
    check(op_point, 4'h4);
    req = 4'($urandom_range(3, 0));
    wr_reg(ttc_pkg::ADDR_REQ, 32'(req));
    wait_cyc(4);
    check(op_point, req);
    wr_reg(ttc_pkg::ADDR_REQ, 32'h9);
    wait_cyc(4);
    check(op_point, req);
    lvl <= 2'h0;
    wait_cyc(8);
    check(op_point, 4'h9);
    // hot alarm around clock-stopped states
    wr_reg(ttc_pkg::ADDR_MODE, 32'h0);
    lp <= 1'b1;
    lvl <= 2'h2;
    wait_cyc(8);
    check(hot_alarm_n, 1'b1);
    lvl <= 2'h0;
    lp <= 1'b0;
    wait_cyc(8);
    lvl <= 2'h2;
    wait_cyc(8);
    lp <= 1'b1;
    lvl <= 2'h0;
    wait_cyc(8);
    check(hot_alarm_n, 1'b0);
    lp <= 1'b0;
    wait_cyc(8);
    check(hot_alarm_n, 1'b1);
    // catastrophic trip with status reads on the bus
    lvl <= 2'h3;
    wait_cyc(5);
    check(catastrophic_trip_n, 1'b0);
    check(core_clk_en, 1'b0);
    rd_reg(ttc_pkg::ADDR_STAT, 32'h12E);
    rd_reg(ttc_pkg::ADDR_ISTAT, 32'h7);
    wait_cyc(20);
    check(power_on, 1'b0);
    lvl <= 2'h0;
    rst <= 1'b1;
    wait_cyc(3);
    rst <= 1'b0;
    wait_cyc(2);
    check(catastrophic_trip_n, 1'b1);
    check(core_clk_en, 1'b1);
    check(op_point, 4'hF);
    check(throttle_active, 1'b0);
    check(power_on, 1'b1);
    results();
  end
endmodule
`default_nettype wire
